// [frpr_host.sv]
// Host serial controller model that sends command frames to the bank.
`timescale 1ns/100ps
module frpr_host (
	// Clock.
	input  wire  ref_clk,
	// Serial pins.
	output logic sck,
	output logic csB,
	output logic si,
	input  wire  so,
	input  wire  soOe_b
);
	// Idle bus: clock low and device deselected.
	initial begin
		sck = 1'b0;
		csB = 1'b1;
		si  = 1'b0;
	end
	// One bit: data set while the clock is low, answer taken at the rise.
	task automatic bitx(input logic d, output logic q);
		sck <= 1'b0;
		si  <= d;
		repeat (4) @(posedge ref_clk);
		q = soOe_b ? ~so : so;  // A released line reads inverted.
		sck <= 1'b1;
		repeat (4) @(posedge ref_clk);
	endtask
	// Opcode byte then one data byte, MSB first; read data returned in rd.
	task automatic frame(input logic [7:0] op, input logic [7:0] dat,
		output logic [7:0] rd);
		logic q;
		int   i;
		csB <= 1'b0;
		repeat (4) @(posedge ref_clk);
		for (i = 7; i >= 0; i--) bitx(op[i], q);
		for (i = 7; i >= 0; i--) begin
			bitx(dat[i], q);
			rd[i] = q;
		end
		sck <= 1'b0;
		@(posedge ref_clk);
		// Released data line must not keep its last level.
		csB <= 1'b1;
		si  <= ~si;
		repeat (8) @(posedge ref_clk);
	endtask
endmodule

// [frpr_map.vh]
// Opcodes, field positions and reset values of the flash register bank.
`ifndef FRPR_MAP_VH
`define FRPR_MAP_VH

// Serial opcodes that write the read-parameter copies.
`define FRPR_OP_SET_PERSIST  8'h65
`define FRPR_OP_SET_LIVE_A   8'hC0
`define FRPR_OP_SET_LIVE_B   8'h63
// Serial opcodes that write and read the function register.
`define FRPR_OP_WR_FUNC      8'hA1
`define FRPR_OP_RD_FUNC      8'hA2
// Serial opcode that reads the live read-parameter copy.
`define FRPR_OP_RD_PARAMS    8'hA3

// Function register fields.
`define FRPR_FN_RST_DIS      0
`define FRPR_FN_BOTTOM       1
`define FRPR_FN_PROGRAM_SUSPENDED_FLAG         2
`define FRPR_FN_ERASE_SUSPENDED_FLAG         3
`define FRPR_FN_LOCK_HI      7
`define FRPR_FN_LOCK_LO      4
`define FRPR_FN_OTP_MASK     8'hF3
`define FRPR_FN_RESET        8'h00

// Read-parameter fields.
`define FRPR_RP_PIN          7
`define FRPR_RP_DUMMY_HI     6
`define FRPR_RP_DUMMY_LO     3
`define FRPR_RP_WRAP         2
`define FRPR_RP_BURST_HI     1
`define FRPR_RP_BURST_LO     0
`define FRPR_RP_RESET        8'h00

// Burst length base, dummy field value that means the command default.
`define FRPR_BURST_BASE      7'h08
`define FRPR_DUMMY_DEFAULT   4'h0

// Array size in blocks and the protect levels where the table bends.
`define FRPR_BLOCKS          10'h200
`define FRPR_LVL_HALF        4'h9
`define FRPR_LVL_ALL         4'hF
`define FRPR_LVL_BIAS        4'h8

// Bit counter end value of a serial byte.
`define FRPR_BIT_LAST        3'h7

`endif

// [frpr_regs.v]
// Function register and read-parameter register pair of a serial flash.
`timescale 1ns/100ps
`include "frpr_map.vh"
module frpr_regs #(
	// Package default of the dedicated reset disable bit.
	parameter [0:0] RESET_DISABLE_DEFAULT = 1'b0,
	// Width of the block index into the array.
	parameter       BLOCK_W               = 9
) (
	// Clock, reset and enable.
	input  wire               ref_clk,
	input  wire               rst_b,
	input  wire               clkEn,
	// Serial link pins.
	input  wire               sck,
	input  wire               csB,
	input  wire               si,
	output reg                so,
	output reg                soOe_b,
	// Device state from the rest of the flash, same clock.
	input  wire               powerUpLoad,
	input  wire               hasDedicatedReset,
	input  wire               quadPinsEnable,
	input  wire               fourLineCommandMode,
	input  wire               programActive,
	input  wire               eraseActive,
	input  wire               suspendCmd,
	input  wire               resumeCmd,
	// Protection query from the program and erase engine.
	input  wire [3:0]         protectLevelBits,
	input  wire [BLOCK_W-1:0] targetBlock,
	input  wire [1:0]         targetInfoRow,
	// Register contents.
	output reg  [7:0]         functionConfigStatus,
	output reg  [7:0]         readParamsPersistent,
	output reg  [7:0]         readParamsLive,
	// Decoded settings for the read path and pins.
	output reg                sharedPinIsPause,
	output reg                sharedPinIsReset,
	output reg                sharedPinIsData3,
	output reg                controlPinsAreData,
	output reg                dedicatedResetActive,
	output reg  [3:0]         dummyCycles,
	output reg                dummyUseDefault,
	output reg                wrapEnable,
	output reg  [6:0]         burstBytes,
	// Protection answers.
	output reg                areaProtected,
	output reg                infoRowLocked
);

	// Command phases within one frame.
	localparam [1:0] PH_OPCODE = 2'b00;  // Waiting for the opcode byte.
	localparam [1:0] PH_DATA   = 2'b01;  // Data byte of a write or read.
	localparam [1:0] PH_IDLE   = 2'b10;  // Rest of frame is ignored.

	// Kinds of command held for the data byte.
	localparam [2:0] CMD_NONE    = 3'h0;  // Nothing to do.
	localparam [2:0] CMD_PERSIST = 3'h1;  // Write persistent parameters.
	localparam [2:0] CMD_LIVE    = 3'h2;  // Write live parameters.
	localparam [2:0] CMD_WR_FUNC = 3'h3;  // Write function register.
	localparam [2:0] CMD_READ    = 3'h4;  // Shift a register out.

	wire       sckFall;     // Settled falling edge of the serial clock.
	wire       frameOpen;   // Chip select is active.
	wire       frameStart;  // Chip select has just gone active.
	wire       byteValid;   // A whole byte has arrived.
	wire [7:0] byteData;    // The byte that arrived.

	reg  [1:0] phase;       // Current command phase.
	reg  [2:0] cmdKind;     // Command waiting for its data byte.
	reg  [7:0] outShift;    // Bits still to be sent on the data out pin.
	reg  [9:0] protCount;   // Blocks covered by the protect level.
	reg  [9:0] blockWide;   // Target block at the width of the count.
	reg        next_prot;   // Protection answer before registering.

	//////////////////////////////////////////////////////////////////////
	// Number of blocks covered by a protect level. Up to level nine the
	// area doubles; above it the unprotected rest halves; all at top.
	function [9:0] protBlocks;
		input [3:0] level;
		begin
			if (level == `FRPR_LVL_ALL) begin
				protBlocks = `FRPR_BLOCKS;
			end else if (level > `FRPR_LVL_HALF) begin
				protBlocks = `FRPR_BLOCKS -
					(`FRPR_BLOCKS >> (level - `FRPR_LVL_BIAS));
			end else if (level == 4'h0) begin
				protBlocks = 10'h000;
			end else begin
				protBlocks = 10'h001 << (level - 4'h1);
			end
		end
	endfunction

	//////////////////////////////////////////////////////////////////////
	// Maps an opcode byte onto the command kind it starts.
	function [2:0] decodeOp;
		input [7:0] op;
		begin
			case (op)
				`FRPR_OP_SET_PERSIST: decodeOp = CMD_PERSIST;
				`FRPR_OP_SET_LIVE_A:  decodeOp = CMD_LIVE;
				`FRPR_OP_SET_LIVE_B:  decodeOp = CMD_LIVE;
				`FRPR_OP_WR_FUNC:     decodeOp = CMD_WR_FUNC;
				`FRPR_OP_RD_FUNC:     decodeOp = CMD_READ;
				`FRPR_OP_RD_PARAMS:   decodeOp = CMD_READ;
				default:              decodeOp = CMD_NONE;
			endcase
		end
	endfunction

	//////////////////////////////////////////////////////////////////////
	// The link front end finds serial clock edges and whole bytes.
	frpr_spi_rx uRx (
		.refClk     (ref_clk),
		.rst_b      (rst_b),
		.clkEn      (clkEn),
		.sck        (sck),
		.csB        (csB),
		.si         (si),
		.sckRise    (),
		.sckFall    (sckFall),
		.frameOpen  (frameOpen),
		.frameStart (frameStart),
		.byteValid  (byteValid),
		.byteData   (byteData)
	);

	//////////////////////////////////////////////////////////////////////
	// Command sequencer and register writes. The opcode picks the copy
	// that the following data byte lands in.
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			phase                <= PH_OPCODE;
			cmdKind              <= CMD_NONE;
			outShift             <= 8'h00;
			so                   <= 1'b0;
			soOe_b               <= 1'b1;
			readParamsPersistent <= `FRPR_RP_RESET;
			readParamsLive       <= `FRPR_RP_RESET;
			functionConfigStatus <= `FRPR_FN_RESET;
			functionConfigStatus[`FRPR_FN_RST_DIS] <=
				RESET_DISABLE_DEFAULT;
		end else if (clkEn) begin
			if (!frameOpen || frameStart) begin
				// Each frame starts over with a new opcode.
				phase   <= PH_OPCODE;
				cmdKind <= CMD_NONE;
				soOe_b  <= 1'b1;
			end else if (byteValid) begin
				case (phase)
					PH_OPCODE: begin
						cmdKind <= decodeOp(byteData);
						phase   <= (decodeOp(byteData) == CMD_NONE) ?
							PH_IDLE : PH_DATA;
						// First fall repeats the MSB for the host.
						if (byteData == `FRPR_OP_RD_FUNC) begin
							outShift <= functionConfigStatus;
							so       <= functionConfigStatus[7];
							soOe_b   <= 1'b0;
						end else if (byteData == `FRPR_OP_RD_PARAMS) begin
							outShift <= readParamsLive;
							so       <= readParamsLive[7];
							soOe_b   <= 1'b0;
						end
					end
					PH_DATA: begin
						phase <= PH_IDLE;
						case (cmdKind)
							CMD_PERSIST: begin
								// Lands in the persistent copy only.
								readParamsPersistent <= byteData;
							end
							CMD_LIVE: begin
								readParamsLive <= byteData;
							end
							CMD_WR_FUNC: begin
								// One-time bits can only be set; suspend bits
								// ignore the written value.
								functionConfigStatus <= functionConfigStatus |
									(byteData & `FRPR_FN_OTP_MASK);
							end
							default: begin
								// Reads have nothing to store.
								cmdKind <= CMD_NONE;
							end
						endcase
					end
					default: begin
						// Extra bytes of a frame are ignored.
						phase <= PH_IDLE;
					end
				endcase
			end else if (sckFall && !soOe_b) begin
				// Next read bit goes out after the falling edge.
				so       <= outShift[7];
				outShift <= {outShift[6:0], 1'b0};
			end
			if (powerUpLoad) begin
				// Power-up copy wins over a serial write to the live copy.
				readParamsLive <= readParamsPersistent;
			end
			// Suspend flags: a suspend of an active operation in the same cycle as a resume wins.
			if (suspendCmd && programActive) begin
				functionConfigStatus[`FRPR_FN_PROGRAM_SUSPENDED_FLAG] <= 1'b1;
			end else if (resumeCmd) begin
				functionConfigStatus[`FRPR_FN_PROGRAM_SUSPENDED_FLAG] <= 1'b0;
			end
			if (suspendCmd && eraseActive) begin
				functionConfigStatus[`FRPR_FN_ERASE_SUSPENDED_FLAG] <= 1'b1;
			end else if (resumeCmd) begin
				functionConfigStatus[`FRPR_FN_ERASE_SUSPENDED_FLAG] <= 1'b0;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Protection test of the target block against the protected area.
	always @* begin
		protCount = protBlocks(protectLevelBits);
		blockWide = 10'h000;
		blockWide[BLOCK_W-1:0] = targetBlock;
		if (functionConfigStatus[`FRPR_FN_BOTTOM]) begin
			next_prot = (blockWide < protCount);
		end else begin
			next_prot = (blockWide >= (`FRPR_BLOCKS - protCount));
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Registered decode of pin roles and read settings from the live copy.
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			sharedPinIsPause     <= 1'b1;
			sharedPinIsReset     <= 1'b0;
			sharedPinIsData3     <= 1'b0;
			controlPinsAreData   <= 1'b0;
			dedicatedResetActive <= 1'b0;
			dummyCycles          <= `FRPR_DUMMY_DEFAULT;
			dummyUseDefault      <= 1'b1;
			wrapEnable           <= 1'b0;
			burstBytes           <= `FRPR_BURST_BASE;
			areaProtected        <= 1'b0;
			infoRowLocked        <= 1'b0;
		end else if (clkEn) begin
			controlPinsAreData <= quadPinsEnable;
			dedicatedResetActive <= hasDedicatedReset &&
				!functionConfigStatus[`FRPR_FN_RST_DIS];
			if (quadPinsEnable || fourLineCommandMode) begin
				// The shared pin carries data line 3.
				sharedPinIsData3 <= 1'b1;
				sharedPinIsPause <= 1'b0;
				sharedPinIsReset <= 1'b0;
			end else if (hasDedicatedReset &&
				!functionConfigStatus[`FRPR_FN_RST_DIS]) begin
				// Dedicated reset pin in use: pause only.
				sharedPinIsData3 <= 1'b0;
				sharedPinIsPause <= 1'b1;
				sharedPinIsReset <= 1'b0;
			end else begin
				// Select bit picks the role; moved reset lands here too.
				sharedPinIsData3 <= 1'b0;
				sharedPinIsPause <= !readParamsLive[`FRPR_RP_PIN];
				sharedPinIsReset <= readParamsLive[`FRPR_RP_PIN];
			end
			dummyCycles <=
				readParamsLive[`FRPR_RP_DUMMY_HI:`FRPR_RP_DUMMY_LO];
			dummyUseDefault <=
				(readParamsLive[`FRPR_RP_DUMMY_HI:`FRPR_RP_DUMMY_LO] ==
				`FRPR_DUMMY_DEFAULT);
			wrapEnable <= readParamsLive[`FRPR_RP_WRAP];
			burstBytes <= `FRPR_BURST_BASE <<
				readParamsLive[`FRPR_RP_BURST_HI:`FRPR_RP_BURST_LO];
			areaProtected <= next_prot;
			infoRowLocked <= functionConfigStatus[
				`FRPR_FN_LOCK_LO + targetInfoRow];
		end
	end

endmodule

// [frpr_regs_properties.sv]
// Concurrent checks on the ports of the flash register bank.
`timescale 1ns/100ps
`include "frpr_map.vh"
module frpr_regs_properties #(
	parameter [0:0] RESET_DISABLE_DEFAULT = 1'b0,
	parameter       BLOCK_W               = 9
) (
	// Clock, reset, enable and serial pins.
	input wire               ref_clk,
	input wire               rst_b,
	input wire               clkEn,
	input wire               sck,
	input wire               csB,
	input wire               si,
	input wire               so,
	input wire               soOe_b,
	// Device state.
	input wire               powerUpLoad,
	input wire               hasDedicatedReset,
	input wire               quadPinsEnable,
	input wire               fourLineCommandMode,
	input wire               programActive,
	input wire               eraseActive,
	input wire               suspendCmd,
	input wire               resumeCmd,
	input wire [3:0]         protectLevelBits,
	input wire [BLOCK_W-1:0] targetBlock,
	input wire [1:0]         targetInfoRow,
	// Register contents and decodes.
	input wire [7:0]         functionConfigStatus,
	input wire [7:0]         readParamsPersistent,
	input wire [7:0]         readParamsLive,
	input wire               sharedPinIsPause,
	input wire               sharedPinIsReset,
	input wire               sharedPinIsData3,
	input wire               controlPinsAreData,
	input wire               dedicatedResetActive,
	input wire [3:0]         dummyCycles,
	input wire               dummyUseDefault,
	input wire               wrapEnable,
	input wire [6:0]         burstBytes,
	input wire               areaProtected,
	input wire               infoRowLocked
);
	// A cycle that runs out of reset; decodes must follow it one cycle on.
	wire go     = rst_b && clkEn;
	wire single = !quadPinsEnable && !fourLineCommandMode;
	wire forced = hasDedicatedReset && !functionConfigStatus[0];
	// Lock bit of the row being queried.
	wire rowBit = functionConfigStatus[{1'b1, targetInfoRow}];
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	////////////////////////////////////////////////////////////////////////
	a_otp_sticky: assert property ($past(rst_b) |->
		(($past(functionConfigStatus) & `FRPR_FN_OTP_MASK)
		& ~functionConfigStatus) == 8'h00) else $error("one-time bit cleared");
	a_program_suspended_flag_set: assert property (go && suspendCmd && programActive
		|=> functionConfigStatus[2]) else $error("program flag not set");
	a_program_suspended_flag_clear: assert property (go && resumeCmd &&
		!(suspendCmd && programActive) |=> !functionConfigStatus[2])
		else $error("program flag not cleared");
	a_erase_suspended_flag_set: assert property (go && suspendCmd && eraseActive
		|=> functionConfigStatus[3]) else $error("erase flag not set");
	a_power_load: assert property (go && powerUpLoad
		|=> readParamsLive == $past(readParamsPersistent))
		else $error("power-up load missed");
	a_burst_decode: assert property (go |=>
		burstBytes == (7'h08 << $past(readParamsLive[1:0])))
		else $error("burst length wrong");
	a_dummy_wrap: assert property (go |=> {dummyCycles, wrapEnable} ==
		{$past(readParamsLive[6:3]), $past(readParamsLive[2])} &&
		dummyUseDefault == ($past(readParamsLive[6:3]) == 4'h0))
		else $error("dummy or wrap decode wrong");
	a_pin_data3: assert property (go && !single
		|=> sharedPinIsData3 && !sharedPinIsPause && !sharedPinIsReset)
		else $error("shared pin not data");
	a_pin_forced: assert property (go && single && forced
		|=> sharedPinIsPause && !sharedPinIsReset) else $error("pause not forced");
	a_pin_select: assert property (go && single && !forced |=>
		sharedPinIsReset == $past(readParamsLive[7]) &&
		sharedPinIsPause == !$past(readParamsLive[7])) else $error("pin role wrong");
	a_row_lock: assert property (go |=> infoRowLocked == $past(rowBit))
		else $error("row lock answer wrong");
	a_ctrl_data: assert property (go |=>
		controlPinsAreData == $past(quadPinsEnable)) else $error("control pins wrong");
	// Main scenarios.
	c_suspend: cover property (go && suspendCmd && programActive);
	c_load: cover property (go && powerUpLoad);
	c_reset_role: cover property (sharedPinIsReset);
endmodule
bind frpr_regs frpr_regs_properties #(
	.RESET_DISABLE_DEFAULT(RESET_DISABLE_DEFAULT), .BLOCK_W(BLOCK_W)) i_props (
	.ref_clk(ref_clk), .rst_b(rst_b), .clkEn(clkEn), .sck(sck), .csB(csB),
	.si(si), .so(so), .soOe_b(soOe_b), .powerUpLoad(powerUpLoad),
	.hasDedicatedReset(hasDedicatedReset), .quadPinsEnable(quadPinsEnable),
	.fourLineCommandMode(fourLineCommandMode), .programActive(programActive),
	.eraseActive(eraseActive), .suspendCmd(suspendCmd), .resumeCmd(resumeCmd),
	.protectLevelBits(protectLevelBits), .targetBlock(targetBlock),
	.targetInfoRow(targetInfoRow), .functionConfigStatus(functionConfigStatus),
	.readParamsPersistent(readParamsPersistent), .readParamsLive(readParamsLive),
	.sharedPinIsPause(sharedPinIsPause), .sharedPinIsReset(sharedPinIsReset),
	.sharedPinIsData3(sharedPinIsData3), .controlPinsAreData(controlPinsAreData),
	.dedicatedResetActive(dedicatedResetActive), .dummyCycles(dummyCycles),
	.dummyUseDefault(dummyUseDefault), .wrapEnable(wrapEnable),
	.burstBytes(burstBytes), .areaProtected(areaProtected),
	.infoRowLocked(infoRowLocked));

// [frpr_spi_rx.v]
// Serial link front end: pin synchronisers, clock edge finder, byte shifter.
`timescale 1ns/100ps
module frpr_spi_rx (
	// Clock, reset and enable.
	input  wire       refClk,
	input  wire       rst_b,
	input  wire       clkEn,
	// Serial pins.
	input  wire       sck,
	input  wire       csB,
	input  wire       si,
	// Decoded link events.
	output wire       sckRise,
	output wire       sckFall,
	output wire       frameOpen,
	output wire       frameStart,
	output reg        byteValid,
	output reg  [7:0] byteData
);

	reg       sckS1;     // First synchroniser stage of the serial clock.
	reg       sckS2;     // Second stage, safe to read.
	reg       sckS3;     // Delayed copy for edge finding.
	reg       csS1;      // First synchroniser stage of chip select.
	reg       csS2;      // Second stage, safe to read.
	reg       csS3;      // Delayed copy for edge finding.
	reg       siS1;      // First synchroniser stage of serial data.
	reg       siS2;      // Second stage, safe to read.
	reg [6:0] shiftReg;  // Bits of the byte gathered so far.
	reg [2:0] bitCnt;    // Bits taken in the current byte.

	//////////////////////////////////////////////////////////////////////
	// Edges are found on the settled stages only.
	assign sckRise    = sckS2 & ~sckS3;
	assign sckFall    = ~sckS2 & sckS3;
	assign frameOpen  = ~csS2;
	assign frameStart = ~csS2 & csS3;

	//////////////////////////////////////////////////////////////////////
	// Two flip-flops on every pin before any logic looks at it.
	always @(posedge refClk) begin
		if (!rst_b) begin
			sckS1 <= 1'b0;
			sckS2 <= 1'b0;
			sckS3 <= 1'b0;
			csS1  <= 1'b1;
			csS2  <= 1'b1;
			csS3  <= 1'b1;
			siS1  <= 1'b0;
			siS2  <= 1'b0;
		end else if (clkEn) begin
			sckS1 <= sck;
			sckS2 <= sckS1;
			sckS3 <= sckS2;
			csS1  <= csB;
			csS2  <= csS1;
			csS3  <= csS2;
			siS1  <= si;
			siS2  <= siS1;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Data is taken on rising serial clock edges, MSB first.
	always @(posedge refClk) begin
		if (!rst_b) begin
			shiftReg  <= 7'h00;
			bitCnt    <= 3'h0;
			byteValid <= 1'b0;
			byteData  <= 8'h00;
		end else if (clkEn) begin
			byteValid <= 1'b0;
			if (!frameOpen) begin
				// A closed frame drops any partial byte.
				bitCnt <= 3'h0;
			end else if (sckRise) begin
				shiftReg <= {shiftReg[5:0], siS2};
				bitCnt   <= bitCnt + 3'h1;
				if (bitCnt == `FRPR_BIT_LAST) begin
					byteValid <= 1'b1;
					byteData  <= {shiftReg, siS2};
				end
			end
		end
	end

endmodule

// [tb_frpr_regs.sv]
// Self-checking bench for the flash register bank.
`timescale 1ns/100ps
`include "frpr_map.vh"
module tb_frpr_regs;
	// Bench-driven inputs.
	logic       ref_clk = 1'b0, rst_b = 1'b0, clkEn = 1'b1;
	logic [2:0] pulses = 3'h0, pins = 3'h0;
	logic [1:0] acts = 2'h0, targetInfoRow = 2'h3;
	logic [3:0] protectLevelBits = 4'h0;
	logic [8:0] targetBlock = 9'h000;
	// Serial pins and design outputs.
	logic       sck, csB, si, so, soOe_b, pinPause, pinReset, pinData3;
	logic       ctrlData, dedReset, useDef, wrapEn, areaProt, rowLocked;
	logic [7:0] fcs, rpp, rpl, rd, d, op;
	logic [6:0] burst;
	logic [3:0] dummy;
	int         error_cnt = 0, compares = 0, i;
	// Pin settings {dedicated, quad, four-line} and the roles they give.
	logic [2:0] pinSet [4] = '{3'h0, 3'h4, 3'h2, 3'h1};
	logic [3:0] pinExp [4] = '{4'h4, 4'h8, 4'h3, 4'h2};
	frpr_regs #(.RESET_DISABLE_DEFAULT(1'b0), .BLOCK_W(9)) i_dut (
		.ref_clk(ref_clk), .rst_b(rst_b), .clkEn(clkEn), .sck(sck), .csB(csB),
		.si(si), .so(so), .soOe_b(soOe_b), .powerUpLoad(pulses[0]),
		.hasDedicatedReset(pins[2]), .quadPinsEnable(pins[1]),
		.fourLineCommandMode(pins[0]), .programActive(acts[1]),
		.eraseActive(acts[0]), .suspendCmd(pulses[1]), .resumeCmd(pulses[2]),
		.protectLevelBits(protectLevelBits), .targetBlock(targetBlock),
		.targetInfoRow(targetInfoRow), .functionConfigStatus(fcs),
		.readParamsPersistent(rpp), .readParamsLive(rpl),
		.sharedPinIsPause(pinPause), .sharedPinIsReset(pinReset),
		.sharedPinIsData3(pinData3), .controlPinsAreData(ctrlData),
		.dedicatedResetActive(dedReset), .dummyCycles(dummy),
		.dummyUseDefault(useDef), .wrapEnable(wrapEn), .burstBytes(burst),
		.areaProtected(areaProt), .infoRowLocked(rowLocked));
	frpr_host i_host (.ref_clk(ref_clk), .sck(sck), .csB(csB), .si(si),
		.so(so), .soOe_b(soOe_b));
	// 20 MHz clock.
	always #25 ref_clk = ~ref_clk;
	////////////////////////////////////////////////////////////////////////
	// Compare with case equality and count.
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Let a level change reach the registered decodes.
	task step;
		repeat (3) @(posedge ref_clk);
	endtask
	// One-cycle pulse on {resume, suspend, power-up load}.
	task pulse(input logic [2:0] p);
		@(posedge ref_clk);
		pulses <= p;
		@(posedge ref_clk);
		pulses <= 3'h0;
		step;
	endtask
	// Protection query against a worked-out answer.
	task prot(input logic [3:0] lvl, input logic [8:0] blk, input logic exp);
		protectLevelBits <= lvl;
		targetBlock <= blk;
		step;
		chk(areaProt, exp);
	endtask
	// Counts and verdict; ends the run.
	task conclude;
		$display("Comparisons %0d, mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// Watchdog well beyond the length of the sequence.
	initial begin
		repeat (20000) @(posedge ref_clk);
		error_cnt++;
		$display("Watchdog expired");
		conclude;
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge ref_clk);
		rst_b <= 1'b1;
		step;
		chk(fcs, 8'h00);
		chk({rpp, rpl, soOe_b}, {16'h0000, 1'b1});
		chk({burst, useDef, wrapEn, pinPause}, {7'h08, 3'h5});
		// Live writes with both opcodes over every burst code.
		for (i = 0; i < 4; i++) begin
			d = {1'b0, 4'(i * 5), i[0], i[1:0]};
			op = i[0] ? `FRPR_OP_SET_LIVE_A : `FRPR_OP_SET_LIVE_B;
			i_host.frame(op, d, rd);
			chk(rpl, d);
			chk(burst, 7'h08 << i);
			chk({dummy, wrapEn}, {d[6:3], d[2]});
			chk(useDef, d[6:3] == 4'h0);
			i_host.frame(`FRPR_OP_RD_PARAMS, 8'h00, rd);
			chk({rd, soOe_b}, {d, 1'b1});
		end
		// Persistent copy waits for the power-up load.
		i_host.frame(`FRPR_OP_SET_PERSIST, 8'hA5, rd);
		chk({rpp, rpl}, {8'hA5, d});
		pulse(3'h1);
		chk(rpl, 8'hA5);
		// An unknown opcode leaves both copies alone.
		i_host.frame(8'h00, 8'h5A, rd);
		chk({rpp, rpl}, 16'hA5A5);
		// Shared pin role for each pin setting.
		for (i = 0; i < 4; i++) begin
			pins <= pinSet[i];
			step;
			chk({pinPause, pinReset, pinData3, ctrlData},
				pinExp[i]);
		end
		// Top placement before the bottom bit is set.
		prot(4'h9, 9'h100, 1'b1);
		prot(4'h9, 9'h0FF, 1'b0);
		prot(4'hA, 9'h080, 1'b1);
		prot(4'hA, 9'h07F, 1'b0);
		// Function writes: flags ignored, one-time bits only set.
		i_host.frame(`FRPR_OP_WR_FUNC, 8'h0E, rd);
		chk({fcs, rowLocked}, {8'h02, 1'b0});
		i_host.frame(`FRPR_OP_WR_FUNC, 8'h00, rd);
		chk(fcs, 8'h02);
		prot(4'h1, 9'h000, 1'b1);
		prot(4'h1, 9'h001, 1'b0);
		prot(4'hF, 9'h1FF, 1'b1);
		prot(4'h0, 9'h000, 1'b0);
		i_host.frame(`FRPR_OP_WR_FUNC, 8'hF1, rd);
		i_host.frame(`FRPR_OP_RD_FUNC, 8'h00, rd);
		chk({fcs, rd, rowLocked}, {16'hF3F3, 1'b1});
		pins <= 3'h4;
		step;
		chk({dedReset, pinReset}, 2'h1);
		// Suspend and resume of program, then of erase.
		for (i = 0; i < 2; i++) begin
			acts <= {~i[0], i[0]};
			pulse(3'h2);
			chk(fcs[3:2], {i[0], ~i[0]});
			pulse(3'h4);
			chk(fcs[3:2], 2'h0);
		end
		conclude;
	end
endmodule
